// >>> rtl/aau_cfg.svh
`ifndef AAU_CFG_SVH
`define AAU_CFG_SVH

// datapath width and register-file depth
`define AAU_DATA_W      8
`define AAU_ADDR_W      8
`define AAU_RF_DEPTH    256
// accumulator reset value
`define AAU_ACC_RESET   8'h00
// destination selector encodings
`define AAU_DEST_ACC    1'b0
`define AAU_DEST_REG    1'b1
// cycles from issue to write-back
`define AAU_EXEC_CYCLES 1

`endif

// >>> rtl/aau_pkg.sv
`default_nettype none
package aau_pkg;
  // operation selector for the issue port
  typedef enum logic [1:0] {
    AAU_OP_NONE,
    AAU_OP_LIT,
    AAU_OP_REG
  } aau_op_t;
endpackage : aau_pkg
`default_nettype wire

// >>> rtl/aau_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "aau_cfg.svh"
module aau_regfile #(
  parameter int DATA_W = `AAU_DATA_W,
  parameter int ADDR_W = `AAU_ADDR_W,
  parameter int DEPTH  = `AAU_RF_DEPTH
) (
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [DEPTH];

  // write port; contents undefined until written, like real file RAM
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, old data on a same-address write
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : aau_regfile
`default_nettype wire

// >>> rtl/aau_add_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "aau_cfg.svh"
// Operation
// - add literal into accumulator
// - add accumulator and addressed file register
// - selector 0 writes accumulator only
// - selector 1 writes file register only on a register add; a literal add always writes accumulator
module aau_add_unit #(
  parameter int DATA_W = `AAU_DATA_W,
  parameter int ADDR_W = `AAU_ADDR_W
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire aau_pkg::aau_op_t     op,
  input  wire logic [DATA_W-1:0]    literal,
  input  wire logic [ADDR_W-1:0]    file_addr,
  input  wire logic                 dest_sel,
  input  wire logic                 ext_wr_en,
  input  wire logic [ADDR_W-1:0]    ext_addr,
  input  wire logic [DATA_W-1:0]    ext_wr_data,
  output logic      [DATA_W-1:0]    ext_rd_data,
  output logic      [DATA_W-1:0]    working_accumulator,
  output logic                      overflow_flag,
  output logic                      carry_flag,
  output logic                      half_carry_flag,
  output logic                      zero_flag,
  output logic                      done
);
  // issue stage: read phase of the two-step execute
  aau_pkg::aau_op_t  op_reg;
  logic [DATA_W-1:0] lit_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              dest_reg;
  logic [DATA_W-1:0] rf_rd;
  logic [ADDR_W-1:0] rf_rd_addr;
  logic              rf_wr_en;
  logic [ADDR_W-1:0] rf_wr_addr;
  logic [DATA_W-1:0] rf_wr_data;
  logic [DATA_W-1:0] operand;
  logic [DATA_W:0]   sum_full;
  logic [4:0]        low_sum;
  logic [DATA_W-1:0] sum;
  logic              ov_next;
  logic              dest_is_reg;

  // file address follows a register-add issue; else the external port
  assign rf_rd_addr = (op == aau_pkg::AAU_OP_REG) ? file_addr : ext_addr;

  aau_regfile #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W),
    .DEPTH  (1 << ADDR_W)
  ) u_rf (
    .clk     (clk),
    .rd_addr (rf_rd_addr),
    .rd_data (rf_rd),
    .wr_en   (rf_wr_en),
    .wr_addr (rf_wr_addr),
    .wr_data (rf_wr_data)
  );

  // latch operands while the file read is in flight
  always_ff @(posedge clk) begin
    if (reset) begin
      op_reg   <= aau_pkg::AAU_OP_NONE;
      lit_reg  <= '0;
      addr_reg <= '0;
      dest_reg <= `AAU_DEST_ACC;
    end else begin
      op_reg   <= op;
      lit_reg  <= literal;
      addr_reg <= file_addr;
      dest_reg <= dest_sel;
    end
  end

  // operand choice and adder, 8-bit wrap by truncation
  assign operand  = (op_reg == aau_pkg::AAU_OP_REG) ? rf_rd : lit_reg;
  assign sum_full = {1'b0, working_accumulator} + {1'b0, operand};
  assign low_sum  = {1'b0, working_accumulator[3:0]} + {1'b0, operand[3:0]};
  assign sum      = sum_full[DATA_W-1:0];
  // signed overflow: like-signed inputs, differently signed result
  assign ov_next  = (working_accumulator[DATA_W-1] == operand[DATA_W-1])
                 && (sum[DATA_W-1] != operand[DATA_W-1]);
  assign dest_is_reg = (op_reg == aau_pkg::AAU_OP_REG)
                    && (dest_reg == `AAU_DEST_REG);

  // file write: add result wins over external write in the same cycle
  always_comb begin
    rf_wr_en   = ext_wr_en;
    rf_wr_addr = ext_addr;
    rf_wr_data = ext_wr_data;
    if (dest_is_reg) begin
      rf_wr_en   = 1'b1;
      rf_wr_addr = addr_reg;
      rf_wr_data = sum;
    end
  end

  // accumulator write-back
  always_ff @(posedge clk) begin
    if (reset) begin
      working_accumulator <= `AAU_ACC_RESET;
    end else if (op_reg == aau_pkg::AAU_OP_LIT) begin
      working_accumulator <= sum;
    end else if (op_reg == aau_pkg::AAU_OP_REG && !dest_reg) begin
      working_accumulator <= sum;
    end
  end

  // status flags for either add
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag   <= 1'b0;
      carry_flag      <= 1'b0;
      half_carry_flag <= 1'b0;
      zero_flag       <= 1'b0;
    end else if (op_reg != aau_pkg::AAU_OP_NONE) begin
      overflow_flag   <= ov_next;
      carry_flag      <= sum_full[DATA_W];
      half_carry_flag <= low_sum[4];
      zero_flag       <= (sum == '0);
    end
  end

  // completion pulse and registered external read data
  always_ff @(posedge clk) begin
    if (reset) begin
      done        <= 1'b0;
      ext_rd_data <= '0;
    end else begin
      done        <= (op_reg != aau_pkg::AAU_OP_NONE);
      ext_rd_data <= rf_rd;
    end
  end

  property p_lit_acc;
    @(posedge clk) disable iff (reset)
      (op == aau_pkg::AAU_OP_LIT)
      |-> ##2 working_accumulator
              == $past(working_accumulator, 1) + $past(literal, 2);
  endproperty
  a_lit_acc: assert property (p_lit_acc)
    else $error("literal add result wrong");

  property p_reg_keeps_acc;
    @(posedge clk) disable iff (reset)
      (op_reg == aau_pkg::AAU_OP_REG && dest_reg)
      |=> $stable(working_accumulator);
  endproperty
  a_reg_keeps_acc: assert property (p_reg_keeps_acc)
    else $error("accumulator changed on file destination");

  property p_reg_writes_file;
    @(posedge clk) disable iff (reset)
      (op_reg == aau_pkg::AAU_OP_REG && dest_reg)
      |-> rf_wr_en && rf_wr_addr == addr_reg && rf_wr_data == sum;
  endproperty
  a_reg_writes_file: assert property (p_reg_writes_file)
    else $error("file write missing for file destination");

  property p_acc_dest;
    @(posedge clk) disable iff (reset)
      (op_reg == aau_pkg::AAU_OP_REG && !dest_reg)
      |-> !dest_is_reg ##1 working_accumulator == $past(sum);
  endproperty
  a_acc_dest: assert property (p_acc_dest)
    else $error("accumulator destination wrong");

  property p_reg_operand;
    @(posedge clk) disable iff (reset)
      (op_reg == aau_pkg::AAU_OP_REG) |-> operand == rf_rd;
  endproperty
  a_reg_operand: assert property (p_reg_operand)
    else $error("file operand not selected");

  property p_done_one;
    @(posedge clk) disable iff (reset)
      (op != aau_pkg::AAU_OP_NONE) |-> ##2 done;
  endproperty
  a_done_one: assert property (p_done_one)
    else $error("completion not two edges after issue");

  property p_zero;
    @(posedge clk) disable iff (reset)
      done |-> zero_flag == (working_accumulator == '0) || $past(dest_reg);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with accumulator");

  property p_carry;
    @(posedge clk) disable iff (reset)
      (op_reg != aau_pkg::AAU_OP_NONE)
      |=> carry_flag == ($past(working_accumulator) > ~$past(operand));
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong");

  // nibble carry seen as a compare, independent of the adder path
  property p_half_carry;
    @(posedge clk) disable iff (reset)
      (op_reg != aau_pkg::AAU_OP_NONE)
      |=> half_carry_flag
          == ($past(working_accumulator[3:0]) > ~$past(operand[3:0]));
  endproperty
  a_half_carry: assert property (p_half_carry)
    else $error("half carry flag wrong");

  // overflow is carry into the sign bit differing from carry out of it
  property p_ovf;
    @(posedge clk) disable iff (reset)
      (op_reg != aau_pkg::AAU_OP_NONE)
      |=> overflow_flag
          == (($past(working_accumulator[DATA_W-2:0])
               > ~$past(operand[DATA_W-2:0]))
              ^ ($past(working_accumulator) > ~$past(operand)));
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag wrong");

  // no completion pulse without an operation in flight
  property p_idle_done;
    @(posedge clk) disable iff (reset)
      (op_reg == aau_pkg::AAU_OP_NONE) |=> !done;
  endproperty
  a_idle_done: assert property (p_idle_done)
    else $error("completion without an operation");
endmodule : aau_add_unit
`default_nettype wire

// >>> testbench/aau_add_unit_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// counted compare, four-state
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module aau_add_unit_tb_top;
  logic             clk;
  logic             reset;
  aau_pkg::aau_op_t op;
  logic [7:0]       literal;
  logic [7:0]       file_addr;
  logic             dest_sel;
  logic             ext_wr_en;
  logic [7:0]       ext_addr;
  logic [7:0]       ext_wr_data;
  wire  [7:0]       ext_rd_data;
  wire  [7:0]       acc;
  wire              ovf, cy, hcy, zf, done;
  int               n_fail;
  int               comparisons;
  logic [7:0]       exp_acc;

  aau_add_unit u_aau_add_unit (.clk(clk), .reset(reset), .op(op),
    .literal(literal), .file_addr(file_addr), .dest_sel(dest_sel),
    .ext_wr_en(ext_wr_en), .ext_addr(ext_addr), .ext_wr_data(ext_wr_data),
    .ext_rd_data(ext_rd_data), .working_accumulator(acc),
    .overflow_flag(ovf), .carry_flag(cy), .half_carry_flag(hcy),
    .zero_flag(zf), .done(done));

  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // file load through the test port
  task ext_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ext_wr_en <= 1'b1; ext_addr <= a; ext_wr_data <= d;
    @(posedge clk);
    ext_wr_en <= 1'b0;
  endtask : ext_wr

  // read lands two edges after the address; one spare edge
  task ext_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    ext_addr <= a;
    repeat (3) @(posedge clk);
    #1;
    `CHK("file", e, ext_rd_data)
  endtask : ext_chk

  // issue one op, rhs is the operand the sum should use
  task automatic do_op(input aau_pkg::aau_op_t o, input logic [7:0] k,
    input logic [7:0] a, input logic d, input logic [7:0] rhs);
    logic [8:0] s;
    logic       hc;
    logic       ov;
    int         i;
    s  = {1'b0, exp_acc} + {1'b0, rhs};
    hc = ({1'b0, exp_acc[3:0]} + {1'b0, rhs[3:0]}) > 5'h0F;
    ov = (exp_acc[7] == rhs[7]) && (s[7] != rhs[7]);
    if (!(o == aau_pkg::AAU_OP_REG && d)) exp_acc = s[7:0];
    @(posedge clk);
    op <= o; literal <= k; file_addr <= a; dest_sel <= d;
    @(posedge clk);
    op <= aau_pkg::AAU_OP_NONE;
    i = 0;
    do begin @(posedge clk); #1; i++; end while (done !== 1'b1 && i < 6);
    if (done !== 1'b1) begin n_fail++; end_sim(); end
    `CHK("acc", exp_acc, acc)
    `CHK("carry", s[8], cy)
    `CHK("half", hc, hcy)
    `CHK("ovf", ov, ovf)
    `CHK("zero", s[7:0] == 8'h00, zf)
    @(posedge clk); #1;
    `CHK("done", 1'b0, done)
  endtask : do_op

  // two literal adds chained on consecutive cycles
  task t_b2b;
    int n;
    @(posedge clk);
    op <= aau_pkg::AAU_OP_LIT; literal <= 8'h01;
    @(posedge clk);
    literal <= 8'h02;
    @(posedge clk);
    op <= aau_pkg::AAU_OP_NONE;
    n = 0;
    exp_acc = exp_acc + 8'h03;
    // first pulse already stands just after this edge, so look before waiting
    repeat (6) begin #1; if (done === 1'b1) n++; @(posedge clk); end
    #1;
    `CHK("pulses", 2, n)
    `CHK("acc", exp_acc, acc)
  endtask : t_b2b

  // mid-run reset returns accumulator, flags and read data to cleared values
  task t_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK("rst acc", 8'h00, acc)
    `CHK("rst flags", 4'h0, {ovf, cy, hcy, zf})
    `CHK("rst done", 1'b0, done)
    `CHK("rst rd", 8'h00, ext_rd_data)
    exp_acc = 8'h00;
  endtask : t_reset

  // main sequence
  initial begin
    reset = 1'b1; op = aau_pkg::AAU_OP_NONE; literal = 8'h00;
    file_addr = 8'h00; dest_sel = 1'b0; ext_wr_en = 1'b0;
    ext_addr = 8'h00; ext_wr_data = 8'h00; n_fail = 0; comparisons = 0;
    exp_acc = 8'h00;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    do_op(aau_pkg::AAU_OP_LIT, 8'h10, 8'h00, 1'b0, 8'h10);
    do_op(aau_pkg::AAU_OP_LIT, 8'h15, 8'h00, 1'b0, 8'h15);
    ext_wr(8'hFF, 8'hC2);
    ext_wr(8'h00, 8'hAF);
    do_op(aau_pkg::AAU_OP_LIT, 8'hF2, 8'h00, 1'b0, 8'hF2);
    do_op(aau_pkg::AAU_OP_REG, 8'h00, 8'hFF, 1'b0, 8'hC2);
    ext_chk(8'hFF, 8'hC2);
    do_op(aau_pkg::AAU_OP_REG, 8'h00, 8'h00, 1'b1, 8'hAF);
    ext_chk(8'h00, 8'h88);
    do_op(aau_pkg::AAU_OP_LIT, 8'h80, 8'h00, 1'b0, 8'h80);
    do_op(aau_pkg::AAU_OP_LIT, 8'hA7, 8'h00, 1'b0, 8'hA7);
    t_b2b();
    do_op(aau_pkg::AAU_OP_LIT, 8'hFE, 8'h00, 1'b0, 8'hFE);
    t_reset();
    do_op(aau_pkg::AAU_OP_LIT, 8'h8C, 8'h00, 1'b0, 8'h8C);
    end_sim();
  end
endmodule : aau_add_unit_tb_top
`default_nettype wire
